// ==== rtl/wbh_top.sv ====
// Buffer-write command handler: decodes the command, takes the data-out bytes, reports sense.
// Assumes a same-clock command sequencer and byte stream; the stored code bank select is a pin.
//
// Behaviour
// - Handle only opcode 3Bh and never write the recording medium.
// - Mode comes from bits 2 to 0 of command byte 1.
// - Modes 000b combined, 010b data, 101b download; others unsupported or reserved.
// - Every accepted valid mode with a nonzero transfer length and no field error enters a data-out phase; zero length reports at once.
// - Combined mode skips four header bytes, stores payload from buffer byte zero.
// - Transfer length bytes 6 to 8 count the data-out bytes taken.
// - Combined mode stores transfer length minus four bytes.
// - Combined length above 60004h ends with illegal request, invalid field.
// - Data mode stores from the offset in command bytes 3 to 5.
// - Data mode past segment capacity ends with illegal request, invalid field.
// - Download commits code to non-volatile store only on success.
// - Download ignores buffer id and offset fields.
// - Successful download raises unit attention for all other initiators.
// - That unit attention carries target operating conditions have changed.
`default_nettype none
`include "wbh_defines.svh"

module wbh_top #(
    parameter int          NI       = 8,
    parameter int          IW       = 3,
    parameter logic [23:0] SEG_CAP  = `WBH_BUF_CAP,
    parameter logic [23:0] CODE_CAP = `WBH_CODE_LEN,
    parameter int          NV_AW    = 16
) (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic                cmd_valid,
    input  wire wbh_pkg::wbh_cdb_t   cmd_cdb,
    input  wire logic [IW-1:0]       cmd_initiator,
    output logic                     cmd_ready,
    input  wire logic                dout_valid,
    input  wire logic [7:0]          dout_data,
    output logic                     dout_ready,
    input  wire logic                xfer_abort,
    output logic                     buf_we,
    output logic [23:0]              buf_addr,
    output logic [7:0]               buf_wdata,
    input  wire logic                nv_bank_pin,
    output logic                     nv_we,
    output logic [NV_AW-1:0]         nv_addr,
    output logic [7:0]               nv_wdata,
    output logic                     nv_bank,
    output logic                     nv_commit,
    output logic                     medium_we,
    output logic                     resp_valid,
    output var  wbh_pkg::wbh_sense_t resp_sense,
    input  wire logic [NI-1:0]       ua_clear,
    output logic [NI-1:0]            ua_pending,
    output var  wbh_pkg::wbh_sense_t ua_sense
);

    wbh_pkg::wbh_state_t state_q;
    wbh_pkg::wbh_req_t   dec_req;
    wbh_pkg::wbh_req_t   req_q;
    logic                dec_hit;
    logic [IW-1:0]       issuer_q;
    logic [23:0]         cnt_q;
    logic [23:0]         addr_q;
    logic                accept;
    logic                take;
    logic                last;
    logic                store;
    logic                dl_done;

    function automatic logic [NI-1:0] onehot(input logic [IW-1:0] idx);
        onehot = NI'(1) << idx;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    wbh_cdb_decode #(
        .SEG_CAP  (SEG_CAP),
        .CODE_CAP (CODE_CAP)
    ) u_decode (
        .cdb (cmd_cdb),
        .hit (dec_hit),
        .req (dec_req)
    );

    wbh_nv_stage #(
        .AW (NV_AW)
    ) u_nv (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .start       (accept && dec_req.mode == wbh_pkg::WBH_M_DOWNLOAD),
        .byte_valid  (take && req_q.mode == wbh_pkg::WBH_M_DOWNLOAD),
        .byte_data   (dout_data),
        .commit      (dl_done),
        .nv_bank_pin (nv_bank_pin),
        .nv_we       (nv_we),
        .nv_addr     (nv_addr),
        .nv_wdata    (nv_wdata),
        .nv_bank     (nv_bank),
        .nv_commit   (nv_commit)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Other opcodes are left for other handlers and never leave idle
    assign cmd_ready  = (state_q == wbh_pkg::WBH_IDLE);
    assign accept     = cmd_valid && dec_hit && cmd_ready;
    assign dout_ready = (state_q == wbh_pkg::WBH_XFER);
    assign take       = dout_valid && dout_ready;
    assign last       = take && (cnt_q == 24'(req_q.length - 1'b1));
    assign store      = take && (req_q.mode == wbh_pkg::WBH_M_DATA ||
                                 (req_q.mode == wbh_pkg::WBH_M_COMBINED && cnt_q >= `WBH_HDR_BYTES));
    assign dl_done    = last && !xfer_abort && (req_q.mode == wbh_pkg::WBH_M_DOWNLOAD);
    assign medium_we  = 1'b0;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= wbh_pkg::WBH_IDLE;
        end else begin
            case (state_q)
                wbh_pkg::WBH_IDLE: begin
                    if (accept) begin
                        // Field errors are reported before any byte is taken
                        if (dec_req.field_err || dec_req.length == 24'h000000) begin
                            state_q <= wbh_pkg::WBH_REPORT;
                        end else begin
                            state_q <= wbh_pkg::WBH_XFER;
                        end
                    end
                end
                wbh_pkg::WBH_XFER: begin
                    if (xfer_abort) begin
                        state_q <= wbh_pkg::WBH_IDLE;
                    end else if (last) begin
                        state_q <= wbh_pkg::WBH_REPORT;
                    end
                end
                wbh_pkg::WBH_REPORT: begin
                    state_q <= wbh_pkg::WBH_IDLE;
                end
                default: begin
                    state_q <= wbh_pkg::WBH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_q    <= '0;
            issuer_q <= '0;
        end else if (accept) begin
            req_q    <= dec_req;
            issuer_q <= cmd_initiator;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q  <= 24'h000000;
            addr_q <= 24'h000000;
        end else if (accept) begin
            cnt_q  <= 24'h000000;
            addr_q <= dec_req.start_addr;
        end else begin
            if (take) begin
                cnt_q <= 24'(cnt_q + 1'b1);
            end
            if (store) begin
                addr_q <= 24'(addr_q + 1'b1);
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            buf_we    <= 1'b0;
            buf_addr  <= 24'h000000;
            buf_wdata <= 8'h00;
        end else begin
            buf_we <= store;
            if (store) begin
                buf_addr  <= addr_q;
                buf_wdata <= dout_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            resp_valid <= 1'b0;
            resp_sense <= '0;
        end else begin
            resp_valid <= (accept && (dec_req.field_err || dec_req.length == 24'h000000)) ||
                          (last && !xfer_abort);
            if (accept && dec_req.field_err) begin
                resp_sense.check <= 1'b1;
                resp_sense.key   <= `WBH_SK_ILLEGAL;
                resp_sense.asc   <= `WBH_ASC_INV_FIELD;
                resp_sense.ascq  <= `WBH_ASCQ_NONE;
            end else if (accept) begin
                resp_sense.check <= 1'b0;
                resp_sense.key   <= `WBH_SK_NONE;
                resp_sense.asc   <= `WBH_ASC_NONE;
                resp_sense.ascq  <= `WBH_ASCQ_NONE;
            end
        end
    end

    // A new attention wins over a clear arriving in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ua_pending <= '0;
        end else if (dl_done && !xfer_abort) begin
            ua_pending <= (ua_pending & ~ua_clear) | ~onehot(issuer_q);
        end else begin
            ua_pending <= ua_pending & ~ua_clear;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ua_sense <= '0;
        end else begin
            ua_sense.check <= 1'b1;
            ua_sense.key   <= `WBH_SK_UNIT_ATTN;
            ua_sense.asc   <= `WBH_ASC_TGT_CHANGED;
            ua_sense.ascq  <= `WBH_ASCQ_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helper counters, only read by the checks below
    logic [23:0] chk_taken_q;
    logic [23:0] chk_stored_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            chk_taken_q  <= 24'h000000;
            chk_stored_q <= 24'h000000;
        end else if (accept) begin
            chk_taken_q  <= 24'h000000;
            chk_stored_q <= 24'h000000;
        end else begin
            chk_taken_q  <= 24'(chk_taken_q + {23'h000000, take});
            chk_stored_q <= 24'(chk_stored_q + {23'h000000, buf_we});
        end
    end

    a_no_medium_write: assert property (@(posedge clk) disable iff (sys_rst)
        medium_we == 1'b0) else $error("medium write seen");

    a_foreign_opcode: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_ready && cmd_valid && cmd_cdb.opcode != 8'h3B) |=> state_q == wbh_pkg::WBH_IDLE)
        else $error("foreign opcode accepted");

    a_bad_mode: assert property (@(posedge clk) disable iff (sys_rst)
        (accept && (cmd_cdb.mode_byte[2:0] == 3'h1 || cmd_cdb.mode_byte[2:0] == 3'h3 ||
                    cmd_cdb.mode_byte[2:0] == 3'h4 || cmd_cdb.mode_byte[2:0] >= 3'h6))
        |=> resp_valid && resp_sense.check && resp_sense.key == 4'h5 && resp_sense.asc == 8'h24
            && !dout_ready ##1 !buf_we) else $error("bad mode not rejected");

    a_xfer_entry: assert property (@(posedge clk) disable iff (sys_rst)
        (accept && cmd_cdb.mode_byte[2:0] == 3'h5 && cmd_cdb.length == 24'h00C000)
        |=> dout_ready && !resp_valid) else $error("no data phase for download");

    a_comb_limit: assert property (@(posedge clk) disable iff (sys_rst)
        (accept && cmd_cdb.mode_byte[2:0] == 3'h0 && cmd_cdb.length > 24'h060004)
        |=> resp_valid && resp_sense.check && resp_sense.key == 4'h5 && resp_sense.asc == 8'h24)
        else $error("combined length over limit accepted");

    a_comb_edge_ok: assert property (@(posedge clk) disable iff (sys_rst)
        (accept && cmd_cdb.mode_byte[2:0] == 3'h0 && cmd_cdb.length == 24'h060004)
        |=> dout_ready) else $error("combined length at limit refused");

    a_seg_limit: assert property (@(posedge clk) disable iff (sys_rst)
        (accept && cmd_cdb.mode_byte[2:0] == 3'h2 &&
         ({1'b0, cmd_cdb.offset} + {1'b0, cmd_cdb.length}) > {1'b0, SEG_CAP})
        |=> resp_valid && resp_sense.check) else $error("segment overrun accepted");

    a_comb_first_addr: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(buf_we) && chk_stored_q == 24'h000000 && req_q.mode == wbh_pkg::WBH_M_COMBINED)
        |-> buf_addr == 24'h000000 && chk_taken_q == 24'h000005) else $error("header not skipped");

    a_data_first_addr: assert property (@(posedge clk) disable iff (sys_rst)
        (buf_we && chk_stored_q == 24'h000000 && req_q.mode == wbh_pkg::WBH_M_DATA)
        |-> buf_addr == req_q.start_addr) else $error("data mode offset wrong");

    a_byte_counts: assert property (@(posedge clk) disable iff (sys_rst)
        (resp_valid && !resp_sense.check && req_q.mode == wbh_pkg::WBH_M_COMBINED &&
         req_q.length >= 24'h000004)
        |-> chk_taken_q == req_q.length &&
            24'(chk_stored_q + {23'h000000, buf_we}) == 24'(req_q.length - 24'h000004))
        else $error("combined byte counts wrong");

    a_commit_good: assert property (@(posedge clk) disable iff (sys_rst)
        nv_commit |-> resp_valid && !resp_sense.check && req_q.mode == wbh_pkg::WBH_M_DOWNLOAD
                      && chk_taken_q == req_q.length) else $error("commit without success");

    a_ua_others: assert property (@(posedge clk) disable iff (sys_rst)
        nv_commit |-> &(ua_pending | onehot(issuer_q))) else $error("attention missing for other");

    a_ua_sense: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(|ua_pending) |-> ua_sense.key == 4'h6 && ua_sense.asc == 8'h3F)
        else $error("attention sense wrong");

endmodule

`default_nettype wire

// ==== rtl/wbh_defines.svh ====
// Constants of the buffer-write command handler: codes, field positions, limits, sense values.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef WBH_DEFINES_SVH
`define WBH_DEFINES_SVH

`define WBH_OPCODE          8'h3B
`define WBH_MODE_MSB        2
`define WBH_MODE_LSB        0
`define WBH_MODE_COMBINED   3'h0
`define WBH_MODE_DATA       3'h2
`define WBH_MODE_DOWNLOAD   3'h5
`define WBH_HDR_BYTES       24'h000004
`define WBH_BUF_CAP         24'h060000
`define WBH_COMB_MAX_LEN    24'h060004
`define WBH_CODE_LEN        24'h00C000
`define WBH_SK_NONE         4'h0
`define WBH_SK_ILLEGAL      4'h5
`define WBH_SK_UNIT_ATTN    4'h6
`define WBH_ASC_NONE        8'h00
`define WBH_ASC_INV_FIELD   8'h24
`define WBH_ASC_TGT_CHANGED 8'h3F
`define WBH_ASCQ_NONE       8'h00

`endif

// ==== rtl/wbh_pkg.sv ====
// Types shared by the buffer-write command handler.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package wbh_pkg;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  mode_byte;
        logic [7:0]  buf_id;
        logic [23:0] offset;
        logic [23:0] length;
        logic [7:0]  control;
    } wbh_cdb_t;

    typedef enum logic [1:0] {
        WBH_M_COMBINED = 2'b00,
        WBH_M_DATA     = 2'b01,
        WBH_M_DOWNLOAD = 2'b10,
        WBH_M_INVALID  = 2'b11
    } wbh_mode_t;

    typedef struct packed {
        wbh_mode_t   mode;
        logic        field_err;
        logic [23:0] start_addr;
        logic [23:0] length;
    } wbh_req_t;

    typedef struct packed {
        logic        check;
        logic [3:0]  key;
        logic [7:0]  asc;
        logic [7:0]  ascq;
    } wbh_sense_t;

    typedef enum logic [1:0] {
        WBH_IDLE   = 2'b00,
        WBH_XFER   = 2'b01,
        WBH_REPORT = 2'b10
    } wbh_state_t;

endpackage

`default_nettype wire

// ==== rtl/wbh_cdb_decode.sv ====
// Combinational decode of a command block into mode, start address, length and field error.
// Assumes a stable command block while it is examined.
`default_nettype none
`include "wbh_defines.svh"

module wbh_cdb_decode #(
    parameter logic [23:0] SEG_CAP  = `WBH_BUF_CAP,
    parameter logic [23:0] CODE_CAP = `WBH_CODE_LEN
) (
    input  wire wbh_pkg::wbh_cdb_t cdb,
    output logic                   hit,
    output var  wbh_pkg::wbh_req_t req
);

    function automatic wbh_pkg::wbh_mode_t mode_of(input logic [2:0] m);
        case (m)
            `WBH_MODE_COMBINED: mode_of = wbh_pkg::WBH_M_COMBINED;
            `WBH_MODE_DATA:     mode_of = wbh_pkg::WBH_M_DATA;
            `WBH_MODE_DOWNLOAD: mode_of = wbh_pkg::WBH_M_DOWNLOAD;
            default:            mode_of = wbh_pkg::WBH_M_INVALID;
        endcase
    endfunction

    always_comb begin
        hit            = (cdb.opcode == `WBH_OPCODE);
        req.mode       = mode_of(cdb.mode_byte[`WBH_MODE_MSB:`WBH_MODE_LSB]);
        req.length     = cdb.length;
        req.start_addr = 24'h000000;
        req.field_err  = 1'b0;
        case (req.mode)
            wbh_pkg::WBH_M_COMBINED: begin
                req.field_err = (cdb.length > `WBH_COMB_MAX_LEN);
            end
            wbh_pkg::WBH_M_DATA: begin
                req.start_addr = cdb.offset;
                req.field_err  = ({1'b0, cdb.offset} + {1'b0, cdb.length}) > {1'b0, SEG_CAP};
            end
            wbh_pkg::WBH_M_DOWNLOAD: begin
                // Buffer id and offset are not looked at in this mode
                req.field_err = (cdb.length > CODE_CAP);
            end
            default: begin
                req.field_err = 1'b1;
            end
        endcase
    end

endmodule

`default_nettype wire

// ==== rtl/wbh_nv_stage.sv ====
// Stages a downloaded code image into the inactive non-volatile bank and commits it.
// Assumes the non-volatile store flips its active bank on a commit pulse and keeps it across power loss.
`default_nettype none
`include "wbh_defines.svh"

module wbh_nv_stage #(
    parameter int AW = 16
) (
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          start,
    input  wire logic          byte_valid,
    input  wire logic [7:0]    byte_data,
    input  wire logic          commit,
    input  wire logic          nv_bank_pin,
    output logic               nv_we,
    output logic [AW-1:0]      nv_addr,
    output logic [7:0]         nv_wdata,
    output logic               nv_bank,
    output logic               nv_commit
);

    logic          bank_meta_q;
    logic          bank_sync_q;
    logic [AW-1:0] addr_q;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bank_meta_q <= 1'b0;
            bank_sync_q <= 1'b0;
        end else begin
            bank_meta_q <= nv_bank_pin;
            bank_sync_q <= bank_meta_q;
        end
    end

    // Writing the idle bank keeps the old code effective until the commit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_q   <= '0;
            nv_bank  <= 1'b0;
            nv_we    <= 1'b0;
            nv_addr  <= '0;
            nv_wdata <= 8'h00;
        end else begin
            nv_we <= byte_valid;
            if (start) begin
                addr_q  <= '0;
                nv_bank <= ~bank_sync_q;
            end else if (byte_valid) begin
                addr_q   <= AW'(addr_q + 1'b1);
                nv_addr  <= addr_q;
                nv_wdata <= byte_data;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            nv_commit <= 1'b0;
        end else begin
            nv_commit <= commit;
        end
    end

endmodule

`default_nettype wire

// ==== verif/wbh_init_model.sv ====
// Initiator-side byte source for the buffer-write command handler bench.
// Assumes a byte is taken at a rising edge where valid and ready are both high.
`default_nettype none

module wbh_init_model (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        go,
    input  wire logic [23:0] count,
    input  wire logic [7:0]  key,
    input  wire logic        stall,
    input  wire logic        dout_ready,
    output logic             dout_valid,
    output logic [7:0]       dout_data
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [23:0] idx;
    logic        taken;
    int          sd;

    initial begin
        sd = 32'hee1f11c1;
        idx = 24'h0;
        taken = 1'b0;
        dout_valid = 1'b0;
        dout_data = 8'h00;
    end

    always @(posedge clk) taken <= go & dout_valid & dout_ready;

    ////////////////////////////////////////////////////////////////////////////////
    // Offered byte is held until taken; an idle line toggles so no stale byte looks valid
    always @(negedge clk) begin
        if (sys_rst || !go) begin
            idx = 24'h0;
            dout_valid = 1'b0;
            dout_data = ~dout_data;
        end else begin
            if (taken) idx = idx + 24'h1;
            if (!dout_valid || taken) begin
                if (idx < count && (!stall || $random(sd) % 2 == 0)) begin
                    dout_valid = 1'b1;
                    dout_data = idx[7:0] ^ key;
                end else begin
                    dout_valid = 1'b0;
                    dout_data = ~dout_data;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ==== verif/wbh_top_tb.sv ====
// Self-checking bench for the buffer-write command handler.
// Assumes the handler under rtl/ and the initiator model beside this file.
`default_nettype none

module wbh_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic                clk, sys_rst, cmd_valid, cmd_ready, dout_valid, dout_ready, xfer_abort, go, stall;
    logic                buf_we, nv_bank_pin, nv_we, nv_bank, nv_commit, medium_we, resp_valid;
    wbh_pkg::wbh_cdb_t   cdb;
    wbh_pkg::wbh_sense_t resp_sense, ua_sense;
    logic [2:0]          ini;
    logic [7:0]          dout_data, buf_wdata, nv_wdata, key, ua_clear, ua_pending;
    logic [15:0]         nv_addr;
    logic [23:0]         buf_addr, cnt, ea, eb, nb, na, nc, nr, r0, off, ln;
    int                  n_errors, tests_run, seed, i;

    wbh_top dut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_cdb(cdb), .cmd_initiator(ini),
        .cmd_ready(cmd_ready), .dout_valid(dout_valid), .dout_data(dout_data), .dout_ready(dout_ready),
        .xfer_abort(xfer_abort), .buf_we(buf_we), .buf_addr(buf_addr), .buf_wdata(buf_wdata),
        .nv_bank_pin(nv_bank_pin), .nv_we(nv_we), .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_bank(nv_bank),
        .nv_commit(nv_commit), .medium_we(medium_we), .resp_valid(resp_valid), .resp_sense(resp_sense),
        .ua_clear(ua_clear), .ua_pending(ua_pending), .ua_sense(ua_sense));

    wbh_init_model host (.clk(clk), .sys_rst(sys_rst), .go(go), .count(cnt), .key(key), .stall(stall),
        .dout_ready(dout_ready), .dout_valid(dout_valid), .dout_data(dout_data));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results;
        if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic timeout;
        n_errors++;
        results();
    endtask

    // Non-volatile store stand-in: the active bank flips on commit
    always @(posedge clk) if (nv_commit) nv_bank_pin <= ~nv_bank_pin;

    always @(posedge clk) begin
        if (!sys_rst) begin
            chk(medium_we, 1'b0);
            if (buf_we) begin
                chk(buf_addr, ea);
                chk(buf_wdata, eb[7:0] ^ key);
                ea = ea + 24'h1;
                eb = eb + 24'h1;
                nb = nb + 24'h1;
            end
            if (nv_we) begin
                chk(nv_addr, na);
                chk(nv_wdata, na[7:0] ^ key);
                na = na + 24'h1;
            end
            if (nv_commit) nc = nc + 24'h1;
            if (resp_valid) nr = nr + 24'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Buffer id is nonzero only where the handler must ignore it
    task automatic issue(input logic [2:0] m, input logic [23:0] o, input logic [23:0] len);
        int j;
        @(negedge clk);
        cdb = '0;
        cdb.opcode = 8'h3B;
        cdb.mode_byte = {5'h00, m};
        cdb.buf_id = (m == 3'h5) ? 8'($random(seed)) : 8'h00;
        cdb.offset = o;
        cdb.length = len;
        ini = 3'($random(seed));
        cmd_valid = 1'b1;
        for (j = 0; j < 50 && cmd_ready !== 1'b1; j++) @(negedge clk);
        if (cmd_ready !== 1'b1) timeout();
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask

    task automatic run(input logic [2:0] m, input logic [23:0] o, input logic [23:0] len, input logic bad,
                       input logic [23:0] a0, input logic [23:0] i0, input logic [23:0] n);
        int j;
        ea = a0;
        eb = i0;
        nb = 24'h0;
        key = 8'($random(seed));
        cnt = bad ? 24'h0 : len;
        go <= 1'b1;
        issue(m, o, len);
        for (j = 0; j < 60000 && resp_valid !== 1'b1; j++) begin
            @(posedge clk);
            #1;
        end
        if (resp_valid !== 1'b1) timeout();
        chk(resp_sense, bad ? 24'h152400 : 24'h0);
        // Last stored byte is counted one edge after the response
        repeat (2) @(negedge clk);
        go <= 1'b0;
        chk(nb, bad ? 24'h0 : n);
        // The model must see go low once to restart its byte index
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hee1f11c1;
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cdb = '0;
        ini = 3'h0;
        xfer_abort = 1'b0;
        nv_bank_pin = 1'b0;
        go = 1'b0;
        stall = 1'b1;
        key = 8'h00;
        cnt = 24'h0;
        ua_clear = 8'h00;
        n_errors = 0;
        tests_run = 0;
        {ea, eb, nb, na, nc, nr} = '0;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        chk(dout_ready, 1'b0);
        run(3'h0, 24'h0, 24'h6, 1'b0, 24'h0, 24'h4, 24'h2);
        run(3'h0, 24'h0, 24'h060005, 1'b1, 24'h0, 24'h0, 24'h0);
        run(3'h2, 24'h05FFFE, 24'h2, 1'b0, 24'h05FFFE, 24'h0, 24'h2);
        run(3'h2, 24'h05FFFE, 24'h3, 1'b1, 24'h0, 24'h0, 24'h0);
        for (i = 0; i < 6; i++) begin
            off = 24'($random(seed)) & 24'h03FFFE;
            ln = 24'h1 + (24'($random(seed)) & 24'h1F);
            run(3'h2, off, ln, 1'b0, off, 24'h0, ln);
        end
        for (i = 0; i < 5; i++) run(3'(15'o76431 >> (3 * i)), 24'h0, 24'h4, 1'b1, 24'h0, 24'h0, 24'h0);
        r0 = nr;
        @(negedge clk);
        cdb.opcode = 8'h3C;
        cmd_valid = 1'b1;
        repeat (4) begin
            @(negedge clk);
            chk(dout_ready, 1'b0);
        end
        cmd_valid = 1'b0;
        chk(nr, r0);
        stall = 1'b0;
        run(3'h5, 24'($random(seed)), 24'h00C000, 1'b0, 24'h0, 24'h0, 24'h0);
        chk(na, 24'h00C000);
        chk(nc, 24'h1);
        chk(nv_bank, 1'b1);
        chk(ua_pending, 8'(~(8'h01 << ini)));
        chk(ua_sense, 24'h163F00);
        @(negedge clk);
        ua_clear = 8'hFF;
        @(negedge clk);
        ua_clear = 8'h00;
        chk(ua_pending, 24'h0);
        // Abort mid-image, then mid-payload at the combined limit: nothing committed or answered
        for (i = 0; i < 2; i++) begin
            na = 24'h0;
            ea = 24'h0;
            eb = 24'h4;
            r0 = nr;
            cnt = i ? 24'h060004 : 24'h00C000;
            go <= 1'b1;
            issue(i ? 3'h0 : 3'h5, 24'h0, cnt);
            repeat (40) @(negedge clk);
            xfer_abort = 1'b1;
            @(negedge clk);
            xfer_abort = 1'b0;
            go <= 1'b0;
            repeat (4) @(negedge clk);
            chk(nr, r0);
        end
        chk(nc, 24'h1);
        chk(nv_bank, 1'b0);
        chk(cmd_ready, 1'b1);
        results();
    end
endmodule

`default_nettype wire
